// >>> core/sfm_error_monitor.sv
/*
 * Serial word engine with bit mismatch, sync loss and parity monitors,
 * sticky error flags, interrupt and an Avalon-MM register slave.
 * Assumes serial clock and data pins come from outside the core clock
 * domain and are several core cycles per half serial period.
 */
`include "sfm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sfm_error_monitor (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [`SFM_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire sfm_pkg::sfm_word_t avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output sfm_pkg::sfm_word_t avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic serial_clk_i,
	input wire logic master_out_line_i,
	output logic master_out_line_o,
	output logic master_out_line_oe_o,
	input wire logic slave_out_line_i,
	output logic slave_out_line_o,
	output logic slave_out_line_oe_o,
	input wire logic slave_ready_line_n_i,
	output logic irq_o
);
	import sfm_pkg::*;

	typedef struct packed
	{
		sfm_state_e state;
		logic run;
		logic master;
		logic par_en;
		logic par_odd;
		sfm_byte_t delay;
		logic flg_bit;
		logic flg_sync;
		logic flg_par;
		logic flg_ovr;
		sfm_word_t int_en;
		logic [8:0] tx_shift;
		logic [8:0] rx_shift;
		logic [3:0] bit_cnt;
		sfm_byte_t dly_cnt;
		logic sclk_prev;
		logic waitreq;
		sfm_word_t rdata;
		logic irq;
		logic mo_out;
		logic mo_oe;
		logic so_out;
		logic so_oe;
	} sfm_top_s;

	sfm_top_s s_r;
	sfm_top_s s_nxt;

	logic [`SFM_SYNC_W-1:0] pins_sync;
	logic sclk_s;
	logic mo_s;
	logic so_s;
	logic ready_n_s;
	logic store_push;
	logic store_pop;
	sfm_byte_t store_push_data;
	sfm_byte_t store_data;
	logic store_full;
	logic store_both_full;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic addr_hit(
		input logic [`SFM_ADDR_W-1:0] addr,
		input logic [`SFM_ADDR_W-1:0] offset
	);
		addr_hit = (addr == offset);
	endfunction : addr_hit

	function automatic sfm_word_t be_merge(
		input sfm_word_t old_val,
		input sfm_word_t new_val,
		input logic [3:0] be
	);
		sfm_word_t res;
		res = old_val;
		for (int i = 0; i < 4; i++)
			if (be[i])
				res[i*8 +: 8] = new_val[i*8 +: 8];
		be_merge = res;
	endfunction : be_merge

	function automatic sfm_word_t flags_word(input sfm_top_s st,
		input logic rx_full);
		sfm_word_t w;
		w = '0;
		w[`SFM_FLG_PAR] = st.flg_par;
		w[`SFM_FLG_SYNC] = st.flg_sync;
		w[`SFM_FLG_BIT] = st.flg_bit;
		w[`SFM_FLG_RSVD] = 1'b0;
		w[`SFM_FLG_OVR] = st.flg_ovr;
		w[`SFM_FLG_RXFULL] = rx_full;
		flags_word = w;
	endfunction : flags_word

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and receive store

	sfm_sync #(
		.W(`SFM_SYNC_W)
	) u_sync (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.pins_i({serial_clk_i, master_out_line_i, slave_out_line_i,
			slave_ready_line_n_i}),
		.pins_o(pins_sync)
	);

	assign {sclk_s, mo_s, so_s, ready_n_s} = pins_sync;

	sfm_rx_store u_rx_store (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.push_i(store_push),
		.push_data_i(store_push_data),
		.pop_i(store_pop),
		.data_o(store_data),
		.data_full_o(store_full),
		.both_full_o(store_both_full)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		logic sclk_rise;
		logic sclk_fall;
		logic req;
		logic accept;
		logic own_pin;
		logic far_pin;
		logic [3:0] nbits;
		logic [3:0] cnt_inc;
		logic [8:0] rx_new;
		sfm_byte_t rx_data;
		logic rx_pbit;
		logic ev_bit;
		logic ev_sync;
		logic ev_par;
		logic ev_ovr;
		sfm_word_t clr;
		sfm_word_t ctrl_old;
		sfm_word_t ctrl_new;
		logic par_calc;

		s_nxt = s_r;
		sclk_rise = sclk_s & ~s_r.sclk_prev;
		sclk_fall = ~sclk_s & s_r.sclk_prev;
		s_nxt.sclk_prev = sclk_s;
		req = avs_read_i | avs_write_i;
		accept = req & ~s_r.waitreq;
		own_pin = s_r.master ? mo_s : so_s;
		far_pin = s_r.master ? so_s : mo_s;
		nbits = s_r.par_en ? `SFM_PAR_BITS : `SFM_WORD_BITS;
		cnt_inc = s_r.bit_cnt + 4'h1;
		rx_new = {s_r.rx_shift[7:0], far_pin};
		rx_data = s_r.par_en ? rx_new[8:1] : rx_new[7:0];
		rx_pbit = rx_new[0];
		ev_bit = 1'b0;
		ev_sync = 1'b0;
		ev_par = 1'b0;
		ev_ovr = 1'b0;
		clr = '0;
		ctrl_old = '0;
		ctrl_new = '0;
		par_calc = 1'b0;
		store_push = 1'b0;
		store_pop = 1'b0;
		store_push_data = rx_data;

		// Bus slave: one wait cycle, then the request is taken
		s_nxt.waitreq = 1'b1;
		if (req && s_r.waitreq)
		begin
			s_nxt.waitreq = 1'b0;
			unique case (avs_address_i)
				`SFM_OFF_CTRL:
				begin
					s_nxt.rdata = '0;
					s_nxt.rdata[`SFM_CTRL_RUN] = s_r.run;
					s_nxt.rdata[`SFM_CTRL_MASTER] = s_r.master;
					s_nxt.rdata[`SFM_CTRL_PAR_EN] = s_r.par_en;
					s_nxt.rdata[`SFM_CTRL_PAR_ODD] = s_r.par_odd;
					s_nxt.rdata[`SFM_CTRL_DLY_HI:`SFM_CTRL_DLY_LO] =
						s_r.delay;
				end
				`SFM_OFF_FLAGS: s_nxt.rdata = flags_word(s_r, store_full);
				`SFM_OFF_INT_EN: s_nxt.rdata = s_r.int_en;
				`SFM_OFF_TX: s_nxt.rdata = {31'h0, s_r.state != SFM_IDLE};
				`SFM_OFF_RX: s_nxt.rdata = {24'h0, store_data};
				default: s_nxt.rdata = '0;
			endcase
		end

		if (accept && avs_write_i)
		begin
			if (addr_hit(avs_address_i, `SFM_OFF_CTRL))
			begin
				ctrl_old[`SFM_CTRL_RUN] = s_r.run;
				ctrl_old[`SFM_CTRL_MASTER] = s_r.master;
				ctrl_old[`SFM_CTRL_PAR_EN] = s_r.par_en;
				ctrl_old[`SFM_CTRL_PAR_ODD] = s_r.par_odd;
				ctrl_old[`SFM_CTRL_DLY_HI:`SFM_CTRL_DLY_LO] = s_r.delay;
				ctrl_new = be_merge(ctrl_old, avs_writedata_i,
					avs_byteenable_i);
				s_nxt.run = ctrl_new[`SFM_CTRL_RUN];
				s_nxt.master = ctrl_new[`SFM_CTRL_MASTER];
				s_nxt.par_en = ctrl_new[`SFM_CTRL_PAR_EN];
				s_nxt.par_odd = ctrl_new[`SFM_CTRL_PAR_ODD];
				s_nxt.delay = ctrl_new[`SFM_CTRL_DLY_HI:`SFM_CTRL_DLY_LO];
				if (!ctrl_new[`SFM_CTRL_RUN])
				begin
					// Parity flag also drops with the run bit
					clr[`SFM_FLG_BIT] = 1'b1;
					clr[`SFM_FLG_SYNC] = 1'b1;
					clr[`SFM_FLG_PAR] = 1'b1;
				end
			end
			if (addr_hit(avs_address_i, `SFM_OFF_FLAGS) ||
				addr_hit(avs_address_i, `SFM_OFF_INT_CLR))
				clr = clr | (be_merge('0, avs_writedata_i, avs_byteenable_i)
					& `SFM_FLG_W1C_MASK);
			if (addr_hit(avs_address_i, `SFM_OFF_INT_EN))
				s_nxt.int_en = be_merge(s_r.int_en, avs_writedata_i,
					avs_byteenable_i) & `SFM_FLG_W1C_MASK;
		end
		store_pop = accept && avs_read_i &&
			addr_hit(avs_address_i, `SFM_OFF_RX);

		// Serial engine
		unique case (s_r.state)
			SFM_IDLE:
			begin
				// Load ignored while stopped or mid-word
				if (accept && avs_write_i && s_r.run &&
					addr_hit(avs_address_i, `SFM_OFF_TX))
				begin
					par_calc = (^avs_writedata_i[7:0]) ^ s_r.par_odd;
					s_nxt.tx_shift = {avs_writedata_i[7:0],
						s_r.par_en & par_calc};
					s_nxt.bit_cnt = '0;
					s_nxt.rx_shift = '0;
					s_nxt.state = SFM_SHIFT;
				end
			end
			SFM_SHIFT:
			begin
				if (sclk_rise)
				begin
					// Receive point, half a period after the transmit edge
					if (own_pin != s_r.tx_shift[8])
						ev_bit = 1'b1;
					s_nxt.rx_shift = rx_new;
					s_nxt.bit_cnt = cnt_inc;
					if (cnt_inc == nbits)
					begin
						store_push = 1'b1;
						ev_ovr = store_both_full;
						if (s_r.par_en &&
							(((^rx_data) ^ s_r.par_odd) != rx_pbit))
							ev_par = 1'b1;
						s_nxt.dly_cnt = s_r.delay;
						s_nxt.state = s_r.master ? SFM_RELEASE
							: SFM_IDLE;
					end
				end
				else if (sclk_fall)
					s_nxt.tx_shift = {s_r.tx_shift[7:0], 1'b0};
			end
			SFM_RELEASE:
			begin
				// Judged after completion, so may trail the receive flag
				if (s_r.dly_cnt != '0)
					s_nxt.dly_cnt = s_r.dly_cnt - 8'h01;
				else
				begin
					ev_sync = s_r.master & ~ready_n_s;
					s_nxt.state = SFM_IDLE;
				end
			end
		endcase

		// Bit error while both buffers hold data also sets the overrun flag
		if (ev_bit && store_both_full)
			ev_ovr = 1'b1;

		if (!s_nxt.run)
			s_nxt.state = SFM_IDLE;

		// Set wins over a clear in the same cycle
		s_nxt.flg_bit = (s_r.flg_bit & ~clr[`SFM_FLG_BIT]) | ev_bit;
		s_nxt.flg_sync = (s_r.flg_sync & ~clr[`SFM_FLG_SYNC]) |
			ev_sync;
		s_nxt.flg_par = (s_r.flg_par & ~clr[`SFM_FLG_PAR]) | ev_par;
		s_nxt.flg_ovr = (s_r.flg_ovr & ~clr[`SFM_FLG_OVR]) | ev_ovr;

		s_nxt.irq = |(flags_word(s_nxt, 1'b0) & s_nxt.int_en);

		// Master keeps its line driven while running; slave only mid-word
		s_nxt.mo_oe = s_nxt.run & s_nxt.master;
		s_nxt.so_oe = s_nxt.run & ~s_nxt.master & (s_nxt.state != SFM_IDLE);
		s_nxt.mo_out = s_nxt.tx_shift[8] & (s_nxt.state != SFM_IDLE);
		s_nxt.so_out = s_nxt.mo_out;
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s_r <= '0;
			s_r.state <= SFM_IDLE;
			s_r.delay <= `SFM_DLY_RESET;
			s_r.waitreq <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign avs_readdata_o = s_r.rdata;
	assign avs_waitrequest_o = s_r.waitreq;
	assign master_out_line_o = s_r.mo_out;
	assign master_out_line_oe_o = s_r.mo_oe;
	assign slave_out_line_o = s_r.so_out;
	assign slave_out_line_oe_o = s_r.so_oe;
	assign irq_o = s_r.irq;

endmodule : sfm_error_monitor
`default_nettype wire

// >>> core/sfm_defs.svh
/*
 * Constants of the serial error flag monitor: register offsets, field
 * positions, reset values and word sizes.
 * Assumes a 32-bit Avalon-MM slave with byte addresses.
 */
`ifndef SFM_DEFS_SVH
`define SFM_DEFS_SVH

`define SFM_ADDR_W 8
`define SFM_OFF_CTRL 8'h00
`define SFM_OFF_FLAGS 8'h04
`define SFM_OFF_INT_EN 8'h08
`define SFM_OFF_INT_CLR 8'h0C
`define SFM_OFF_TX 8'h10
`define SFM_OFF_RX 8'h14

`define SFM_CTRL_RUN 0
`define SFM_CTRL_MASTER 1
`define SFM_CTRL_PAR_EN 2
`define SFM_CTRL_PAR_ODD 3
`define SFM_CTRL_DLY_LO 8
`define SFM_CTRL_DLY_HI 15

`define SFM_FLG_PAR 2
`define SFM_FLG_SYNC 3
`define SFM_FLG_BIT 4
`define SFM_FLG_RSVD 5
`define SFM_FLG_OVR 6
`define SFM_FLG_RXFULL 8
`define SFM_FLG_W1C_MASK 32'h0000005C

`define SFM_DLY_RESET 8'h04
`define SFM_WORD_BITS 4'h8
`define SFM_PAR_BITS 4'h9
`define SFM_SYNC_W 4

`endif

// >>> core/sfm_pkg.sv
/*
 * Types shared by the serial error flag monitor modules.
 * Assumes the constants header is included by each design file that uses its macros.
 */
package sfm_pkg;

	typedef enum logic [2:0]
	{
		SFM_IDLE = 3'b001,
		SFM_SHIFT = 3'b010,
		SFM_RELEASE = 3'b100
	} sfm_state_e;

	typedef logic [31:0] sfm_word_t;
	typedef logic [7:0] sfm_byte_t;

endpackage : sfm_pkg

// >>> core/sfm_sync.sv
/*
 * Two-stage synchroniser for pins from outside the core clock domain.
 * Assumes each pin is a plain level; the first stage feeds only the second.
 */
`timescale 1ns/1ps
`default_nettype none

module sfm_sync #(
	parameter int W = 4
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [W-1:0] pins_i,
	output logic [W-1:0] pins_o
);
	import sfm_pkg::*;

	typedef struct packed
	{
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sfm_sync_s;

	sfm_sync_s s_r;
	sfm_sync_s s_nxt;

	always_comb
	begin
		s_nxt.meta = pins_i;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign pins_o = s_r.stable;

endmodule : sfm_sync
`default_nettype wire

// >>> core/sfm_rx_store.sv
/*
 * Two-word receive store: a visible data word and a hold word behind it.
 * Assumes push and pop are single-cycle pulses from the core clock domain.
 */
`include "sfm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sfm_rx_store (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic push_i,
	input wire sfm_pkg::sfm_byte_t push_data_i,
	input wire logic pop_i,
	output sfm_pkg::sfm_byte_t data_o,
	output logic data_full_o,
	output logic both_full_o
);
	import sfm_pkg::*;

	typedef struct packed
	{
		sfm_byte_t data;
		sfm_byte_t hold;
		logic data_full;
		logic hold_full;
	} sfm_store_s;

	sfm_store_s s_r;
	sfm_store_s s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (pop_i)
		begin
			if (s_r.hold_full)
			begin
				s_nxt.data = s_r.hold;
				s_nxt.hold_full = 1'b0;
			end
			else
				s_nxt.data_full = 1'b0;
		end
		if (push_i)
		begin
			// Full store: newest word overwrites the hold word
			if (!s_nxt.data_full)
			begin
				s_nxt.data = push_data_i;
				s_nxt.data_full = 1'b1;
			end
			else
			begin
				s_nxt.hold = push_data_i;
				s_nxt.hold_full = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign data_o = s_r.data;
	assign data_full_o = s_r.data_full;
	assign both_full_o = s_r.data_full & s_r.hold_full;

endmodule : sfm_rx_store
`default_nettype wire

// >>> test/sfm_chk.sv
/* Checker of the monitor's register slave and data pin drivers.
 Bound to sfm_error_monitor; sees only its ports. */
`include "sfm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sfm_chk
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [`SFM_ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire sfm_pkg::sfm_word_t avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic master_out_line_oe_o,
	input wire logic slave_out_line_oe_o
);
	import sfm_pkg::*;
	sfm_word_t last_r;
	logic valid_r;
	logic rd_ans;
	logic wr_ans;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	sequence s_rd(logic [7:0] a);
		rd_ans && avs_address_i == a;
	endsequence
	assign rd_ans = !avs_waitrequest_o && avs_read_i;
	assign wr_ans = !avs_waitrequest_o && avs_write_i;
	////////////////////////////////////////////////////////////////
	// Any write that might clear a flag voids the snapshot
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			valid_r <= 1'h0;
			last_r <= 32'h0;
		end
		else if (wr_ans && avs_address_i <= `SFM_OFF_INT_CLR)
			valid_r <= 1'h0;
		else if (rd_ans && avs_address_i == `SFM_OFF_FLAGS)
		begin
			valid_r <= 1'h1;
			last_r <= avs_readdata_o;
		end
	end
	////////////////////////////////////////////////////////////////
	a_wait_answer: assert property ((avs_read_i || avs_write_i) &&
		avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
	a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer too long");
	a_rsvd_zero: assert property (
		s_rd(`SFM_OFF_FLAGS) |-> avs_readdata_o[`SFM_FLG_RSVD] == 1'h0)
		else $error("reserved flag set");
	a_flag_layout: assert property (s_rd(`SFM_OFF_FLAGS) |->
		(avs_readdata_o & ~32'h0000017C) == 32'h0) else $error("bad flag");
	a_clr_zero: assert property (s_rd(`SFM_OFF_INT_CLR) |->
		avs_readdata_o == 32'h0) else $error("clear reg read");
	a_unmapped_zero: assert property (rd_ans && avs_address_i > `SFM_OFF_RX
		|-> avs_readdata_o == 32'h0) else $error("unmapped read");
	a_flags_sticky: assert property (
		valid_r ##0 s_rd(`SFM_OFF_FLAGS) |-> (avs_readdata_o & last_r &
		32'h5C) == (last_r & 32'h5C)) else $error("flag lost");
	a_one_driver: assert property (!(master_out_line_oe_o &&
		slave_out_line_oe_o)) else $error("both pins driven");
endmodule : sfm_chk

bind sfm_error_monitor sfm_chk u_chk
(
	.core_clk_i,
	.reset_i,
	.avs_address_i,
	.avs_read_i,
	.avs_write_i,
	.avs_readdata_o,
	.avs_waitrequest_o,
	.master_out_line_oe_o,
	.slave_out_line_oe_o
);
`default_nettype wire

// >>> test/sfm_far_end.sv
/* Far-side serial device: clocks each word, drives the line the block
 receives on, answers on the ready line. Resolves both data wires. */
`timescale 1ns/1ps
`default_nettype none

module sfm_far_end
(
	input wire logic mo_i,
	input wire logic mo_oe_i,
	input wire logic so_i,
	input wire logic so_oe_i,
	output logic sclk_o,
	output logic mo_w_o,
	output logic so_w_o,
	output logic ready_n_o
);
	logic far_d;
	logic flip;
	logic [8:0] got;
	initial
	begin
		sclk_o = 1'h0;
		ready_n_o = 1'h1;
		far_d = 1'h0;
		flip = 1'h0;
		got = 9'h0;
	end
	// A fighting driver is modelled by turning the block's bit over
	assign mo_w_o = mo_oe_i ? mo_i ^ flip : far_d;
	assign so_w_o = so_oe_i ? so_i ^ flip : far_d;
	task automatic frame(input logic [8:0] v, input int n,
		input logic [8:0] fm, input logic late);
		ready_n_o = 1'h0;
		#7;
		for (int i = n - 1; i >= 0; i--)
		begin
			far_d = v[i];
			flip = fm[i];
			#100;
			sclk_o = 1'h1;
			got = {got[7:0], mo_oe_i ? mo_w_o : so_w_o};
			if (i == 0 && !late)
				ready_n_o = 1'h1; // Prompt release
			#100;
			sclk_o = 1'h0;
		end
		flip = 1'h0;
		far_d = ~far_d; // Released line shows the inverse
		#500;
		ready_n_o = 1'h1; // Slow release, past the delay
	endtask : frame
endmodule : sfm_far_end
`default_nettype wire

// >>> test/test_spi_error_flag_monitor.sv
/* Self-checking bench: registers, bit mismatch, sync loss, parity and
 overrun. Assumes sfm_far_end and the bound checker are compiled. */
`include "sfm_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module test_spi_error_flag_monitor;
	import sfm_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] addr = 8'h0;
	logic rd = 1'h0;
	logic wr = 1'h0;
	sfm_word_t wdata = 32'h0;
	sfm_word_t rdata, q;
	logic wait_w, irq, sclk, mo, mo_oe, so, so_oe, mo_w, so_w, rdy_n;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	sfm_error_monitor dut (.core_clk_i(clk), .reset_i(rst),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wait_w),
		.serial_clk_i(sclk), .master_out_line_i(mo_w),
		.master_out_line_o(mo), .master_out_line_oe_o(mo_oe),
		.slave_out_line_i(so_w), .slave_out_line_o(so),
		.slave_out_line_oe_o(so_oe), .slave_ready_line_n_i(rdy_n),
		.irq_o(irq));
	sfm_far_end far (.mo_i(mo), .mo_oe_i(mo_oe), .so_i(so), .so_oe_i(so_oe),
		.sclk_o(sclk), .mo_w_o(mo_w), .so_w_o(so_w), .ready_n_o(rdy_n));
	////////////////////////////////////////////////////////////////
	task automatic summarize;
		if (err_total == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	task automatic chk(input string what, input sfm_word_t seen,
		input sfm_word_t exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// No local limit: a hung slave is caught by the cycle ceiling
	task automatic bus(input logic w, input logic [7:0] a, input sfm_word_t d,
		output sfm_word_t r);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do
		begin
			@(posedge clk);
		end
		while (wait_w !== 1'h0);
		r = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask : bus
	task automatic rchk(input string what, input logic [7:0] a,
		input sfm_word_t exp);
		bus(1'h0, a, 32'h0, q);
		chk(what, q, exp);
	endtask : rchk
	function automatic logic par(input logic [7:0] d, input logic odd);
		return ^d ^ odd;
	endfunction : par
	// Busy is polled, so a slow engine never fails by timing alone
	task automatic word(input logic [7:0] tx, input logic [8:0] v, input int n,
		input logic [8:0] fm, input logic late, input logic pop);
		bus(1'h1, `SFM_OFF_TX, {24'h0, tx}, q);
		far.frame(v, n, fm, late);
		do
		begin
			bus(1'h0, `SFM_OFF_TX, 32'h0, q);
		end
		while (q[0] !== 1'h0);
		if (pop)
			rchk("rx data", `SFM_OFF_RX, {24'h0, v[n-1 -: 8]});
	endtask : word
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rchk("ctrl", `SFM_OFF_CTRL, 32'h00000400);
		bus(1'h1, `SFM_OFF_FLAGS, 32'h20, q);
		rchk("reserved", `SFM_OFF_FLAGS, 32'h0);
		rchk("unmapped", 8'h20, 32'h0);
		rchk("clear reg", `SFM_OFF_INT_CLR, 32'h0);
	endtask : t_regs
	task automatic t_parity;
		for (int odd = 0; odd < 2; odd++)
		begin
			bus(1'h1, `SFM_OFF_CTRL, odd[0] ? 32'h40F : 32'h407, q);
			word(8'hA5, {8'h3C, par(8'h3C, odd[0]) ^ odd[0]}, 9, 9'h0, 1'h0, 1'h1);
			chk("sent", {23'h0, far.got}, {23'h0, 8'hA5, par(8'hA5, odd[0])});
			rchk("parity", `SFM_OFF_FLAGS, odd[0] ? 32'h4 : 32'h0);
			bus(1'h1, `SFM_OFF_FLAGS, 32'h4, q);
		end
	endtask : t_parity
	task automatic t_bit_err;
		bus(1'h1, `SFM_OFF_CTRL, 32'h403, q);
		bus(1'h1, `SFM_OFF_INT_EN, 32'h10, q);
		word(8'h5A, 9'h0C3, 8, 9'h020, 1'h0, 1'h1);
		rchk("bit flag", `SFM_OFF_FLAGS, 32'h10);
		repeat (3) @(posedge clk);
		chk("irq on", {31'h0, irq}, 32'h1);
		bus(1'h1, `SFM_OFF_INT_EN, 32'h0, q);
		repeat (3) @(posedge clk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		bus(1'h1, `SFM_OFF_FLAGS, 32'h0, q);
		rchk("kept", `SFM_OFF_FLAGS, 32'h10);
		bus(1'h1, `SFM_OFF_INT_CLR, 32'h10, q);
		rchk("cleared", `SFM_OFF_FLAGS, 32'h0);
		word(8'h5A, 9'h0C3, 8, 9'h001, 1'h0, 1'h1);
		rchk("bit again", `SFM_OFF_FLAGS, 32'h10);
		bus(1'h1, `SFM_OFF_CTRL, 32'h402, q);
		rchk("run off", `SFM_OFF_FLAGS, 32'h0);
	endtask : t_bit_err
	task automatic t_sync;
		bus(1'h1, `SFM_OFF_CTRL, 32'h403, q);
		word(8'h81, 9'h018, 8, 9'h0, 1'h1, 1'h1);
		rchk("sync", `SFM_OFF_FLAGS, 32'h8);
		word(8'h7E, 9'h066, 8, 9'h0, 1'h0, 1'h1);
		rchk("sync kept", `SFM_OFF_FLAGS, 32'h8);
		bus(1'h1, `SFM_OFF_CTRL, 32'h400, q);
		rchk("run off", `SFM_OFF_FLAGS, 32'h0);
		bus(1'h1, `SFM_OFF_CTRL, 32'h401, q);
		word(8'h99, 9'h042, 8, 9'h0, 1'h1, 1'h1);
		rchk("slave", `SFM_OFF_FLAGS, 32'h0);
		chk("slave sent", {24'h0, far.got[7:0]}, 32'h99);
	endtask : t_sync
	task automatic t_overrun;
		bus(1'h1, `SFM_OFF_CTRL, 32'h403, q);
		repeat (2) word(8'h11, 9'h024, 8, 9'h0, 1'h0, 1'h0);
		word(8'h11, 9'h024, 8, 9'h004, 1'h0, 1'h0);
		rchk("overrun", `SFM_OFF_FLAGS, 32'h150);
		bus(1'h1, `SFM_OFF_FLAGS, 32'h50, q);
		repeat (2) bus(1'h0, `SFM_OFF_RX, 32'h0, q);
		rchk("drained", `SFM_OFF_FLAGS, 32'h0);
	endtask : t_overrun
	////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		t_regs();
		t_parity();
		t_bit_err();
		t_sync();
		t_overrun();
		summarize();
	end
endmodule : test_spi_error_flag_monitor
`default_nettype wire
